// [slsl_pkg.sv]
package slsl_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] SLSL_OFS_CTRL = 8'h00;
   localparam logic [7:0] SLSL_OFS_HOST = 8'h04;
   localparam logic [7:0] SLSL_OFS_CMD_POS = 8'h08;
   localparam logic [7:0] SLSL_OFS_LATCH_POS = 8'h0C;
   localparam logic [7:0] SLSL_OFS_STATUS = 8'h10;
   localparam logic [7:0] SLSL_OFS_ACTION = 8'h14;
   localparam logic [7:0] SLSL_OFS_INT_STATUS = 8'h18;
   localparam logic [7:0] SLSL_OFS_INT_MASK = 8'h1C;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int SLSL_CTRL_SRC = 0;
   localparam int SLSL_CTRL_DIR = 1;
   localparam int SLSL_CTRL_AUTO = 2;
   localparam int SLSL_CTRL_CSP = 3;
   localparam int SLSL_CTRL_STOP_LSB = 4;
   localparam logic [5:0] SLSL_CTRL_RESET = 6'h00;
   // ----------------------------------------
   // host limit fields
   // ----------------------------------------
   localparam int SLSL_HOST_UPPER = 0;
   localparam int SLSL_HOST_LOWER = 1;
   localparam int SLSL_HOST_DOG = 2;
   localparam logic [2:0] SLSL_HOST_RESET = 3'h3;
   // ----------------------------------------
   // action and interrupt fields
   // ----------------------------------------
   localparam int SLSL_ACT_SET_HOME = 0;
   localparam int SLSL_ACT_CLR_ALARM = 1;
   localparam int SLSL_INT_STROKE = 0;
   localparam int SLSL_INT_CMD_ERR = 1;
   // ----------------------------------------
   // position check
   // ----------------------------------------
   localparam logic signed [32:0] SLSL_CMD_ERR_MARGIN = 33'sh0_0000_001E;
endpackage : slsl_pkg

// [slsl_stroke_limit.sv]
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
// How it works
// - source select 0 takes forward end, reverse end and dog from local pins.
// - source select 1 takes upper, lower and dog values written by the controller.
// - direction 0 reports forward end as upper flag, reverse end as lower flag.
// - direction 1 reports reverse end as upper flag, forward end as lower flag.
// - automatic-on forces both local end inputs on, so with source select 0 no stroke stop occurs.
// - limit inputs are active low: on means released, off means limit in effect.
// - any end or limit signal off stops the motor with the configured method.
// - in csp, command beyond latched stroke position by over 30 raises alarm.
// - command error alarm clears home established; controller must home again.
module slsl_stroke_limit
   import slsl_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // local switch pins, high while the contact is closed
   input wire logic forward_end_switch,
   input wire logic reverse_end_switch,
   input wire logic proximity_dog,
   // reported to the controller and the drive
   output logic upper_limit_flag,
   output logic lower_limit_flag,
   output logic dog_flag,
   output logic motor_stop,
   output logic [1:0] stop_method,
   output logic command_error_alarm,
   output logic home_established,
   output logic irq
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;

   // switches sit at released (on) during reset so no false stop is seen
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta <= 3'h7;
         pin_sync <= 3'h7;
      end
      else
      begin
         pin_meta <= {proximity_dog, reverse_end_switch, forward_end_switch};
         pin_sync <= pin_meta;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [5:0] ctrl;
   logic [2:0] host_lim;
   logic [31:0] cmd_pos;
   logic [31:0] latch_pos;
   logic [1:0] int_status;
   logic [1:0] int_mask;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic limit_source_select;
   logic travel_direction_select;
   logic auto_on;
   logic csp_mode;

   assign limit_source_select = ctrl[SLSL_CTRL_SRC];
   assign travel_direction_select = ctrl[SLSL_CTRL_DIR];
   assign auto_on = ctrl[SLSL_CTRL_AUTO];
   assign csp_mode = ctrl[SLSL_CTRL_CSP];
   assign stop_method = ctrl[SLSL_CTRL_STOP_LSB +: 2];

   // one wait state: pready rises in the second access cycle, writes land with it
   assign wr_en = psel && penable && pready && pwrite && addr_ok;
   assign rd_en = psel && penable && !pready && !pwrite;
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= SLSL_OFS_INT_MASK);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= SLSL_CTRL_RESET;
         host_lim <= SLSL_HOST_RESET;
         cmd_pos <= 32'h0000_0000;
         int_mask <= 2'h0;
      end
      else if (wr_en)
      begin
         case (paddr)
            SLSL_OFS_CTRL: ctrl <= pwdata[5:0];
            SLSL_OFS_HOST: host_lim <= pwdata[2:0];
            SLSL_OFS_CMD_POS: cmd_pos <= pwdata;
            SLSL_OFS_INT_MASK: int_mask <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         case (paddr)
            SLSL_OFS_CTRL: prdata <= {26'h0, ctrl};
            SLSL_OFS_HOST: prdata <= {29'h0, host_lim};
            SLSL_OFS_CMD_POS: prdata <= cmd_pos;
            SLSL_OFS_LATCH_POS: prdata <= latch_pos;
            SLSL_OFS_STATUS: prdata <= {26'h0, home_established, command_error_alarm,
                                        motor_stop, dog_flag, lower_limit_flag,
                                        upper_limit_flag};
            SLSL_OFS_INT_STATUS: prdata <= {30'h0, int_status};
            SLSL_OFS_INT_MASK: prdata <= {30'h0, int_mask};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // source select and direction mapping
   // ----------------------------------------
   logic fwd_eff;
   logic rev_eff;
   logic next_upper;
   logic next_lower;
   logic next_dog;
   logic next_stop;

   always_comb
   begin
      fwd_eff = auto_on | pin_sync[0];
      rev_eff = auto_on | pin_sync[1];
      if (limit_source_select)
      begin
         next_upper = host_lim[SLSL_HOST_UPPER];
         next_lower = host_lim[SLSL_HOST_LOWER];
         next_dog = host_lim[SLSL_HOST_DOG];
      end
      else
      begin
         next_upper = travel_direction_select ? rev_eff : fwd_eff;
         next_lower = travel_direction_select ? fwd_eff : rev_eff;
         next_dog = pin_sync[2];
      end
      // low level is a limit in effect
      next_stop = !(next_upper && next_lower);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upper_limit_flag <= 1'b1;
         lower_limit_flag <= 1'b1;
         dog_flag <= 1'b1;
         motor_stop <= 1'b0;
      end
      else
      begin
         upper_limit_flag <= next_upper;
         lower_limit_flag <= next_lower;
         dog_flag <= next_dog;
         motor_stop <= next_stop;
      end
   end

   // ----------------------------------------
   // position overrun check
   // ----------------------------------------
   logic stroke_event;
   logic signed [32:0] overrun;
   logic over_limit;
   logic alarm_event;

   assign stroke_event = next_stop && !motor_stop;
   assign overrun = signed'({cmd_pos[31], cmd_pos}) - signed'({latch_pos[31], latch_pos});
   // the controller is trusted to freeze its command, so only excess is judged
   assign over_limit = (!upper_limit_flag && (overrun > SLSL_CMD_ERR_MARGIN)) ||
                       (!lower_limit_flag && (overrun < -SLSL_CMD_ERR_MARGIN));
   assign alarm_event = csp_mode && motor_stop && over_limit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch_pos <= 32'h0000_0000;
      else if (stroke_event)
         latch_pos <= cmd_pos;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         command_error_alarm <= 1'b0;
      else if (alarm_event)
         command_error_alarm <= 1'b1;
      else if (wr_en && paddr == SLSL_OFS_ACTION && pwdata[SLSL_ACT_CLR_ALARM])
         command_error_alarm <= 1'b0;
   end

   // homing cannot be declared while the alarm still stands
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         home_established <= 1'b0;
      else if (alarm_event || command_error_alarm)
         home_established <= 1'b0;
      else if (wr_en && paddr == SLSL_OFS_ACTION && pwdata[SLSL_ACT_SET_HOME])
         home_established <= 1'b1;
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   logic [1:0] int_set;
   logic [1:0] int_clr;

   assign int_set = {alarm_event, stroke_event};
   assign int_clr = (wr_en && paddr == SLSL_OFS_INT_STATUS) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_status <= 2'h0;
      else
         int_status <= (int_status & ~int_clr) | int_set; // set wins over clear
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(((int_status & ~int_clr) | int_set) & int_mask);
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_host_source;
      @(posedge pclk) disable iff (!presetn)
      limit_source_select |=> (upper_limit_flag == $past(host_lim[SLSL_HOST_UPPER])) &&
                              (lower_limit_flag == $past(host_lim[SLSL_HOST_LOWER]));
   endproperty
   a_host_source: assert property (p_host_source) else $error("host limits not used");

   property p_local_dir0;
      @(posedge pclk) disable iff (!presetn)
      (!limit_source_select && !travel_direction_select && !auto_on)
         |=> (upper_limit_flag == $past(pin_sync[0])) && (lower_limit_flag == $past(pin_sync[1]));
   endproperty
   a_local_dir0: assert property (p_local_dir0) else $error("direction 0 mapping wrong");

   property p_local_dir1;
      @(posedge pclk) disable iff (!presetn)
      (!limit_source_select && travel_direction_select && !auto_on)
         |=> (upper_limit_flag == $past(pin_sync[1])) && (lower_limit_flag == $past(pin_sync[0]));
   endproperty
   a_local_dir1: assert property (p_local_dir1) else $error("direction 1 mapping wrong");

   property p_auto_on;
      @(posedge pclk) disable iff (!presetn)
      (!limit_source_select && auto_on) |=> upper_limit_flag && lower_limit_flag && !motor_stop;
   endproperty
   a_auto_on: assert property (p_auto_on) else $error("auto on still stops");

   property p_active_low;
      @(posedge pclk) disable iff (!presetn)
      (!limit_source_select && !auto_on && !travel_direction_select && !pin_sync[0])
         |=> !upper_limit_flag ##0 motor_stop;
   endproperty
   a_active_low: assert property (p_active_low) else $error("open contact not a limit");

   property p_stop;
      @(posedge pclk) disable iff (!presetn)
      motor_stop == !(upper_limit_flag && lower_limit_flag);
   endproperty
   a_stop: assert property (p_stop) else $error("stop does not follow limits");

   property p_alarm_raise;
      @(posedge pclk) disable iff (!presetn)
      (csp_mode && motor_stop && !upper_limit_flag && overrun > SLSL_CMD_ERR_MARGIN)
         |=> command_error_alarm && int_status[SLSL_INT_CMD_ERR];
   endproperty
   a_alarm_raise: assert property (p_alarm_raise) else $error("overrun not alarmed");

   property p_alarm_cause;
      @(posedge pclk) disable iff (!presetn)
      $rose(command_error_alarm) |-> $past(csp_mode) && $past(motor_stop);
   endproperty
   a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without cause");

   property p_home_lost;
      @(posedge pclk) disable iff (!presetn)
      command_error_alarm |-> !home_established;
   endproperty
   a_home_lost: assert property (p_home_lost) else $error("home kept after alarm");

   c_stroke_stop: cover property (@(posedge pclk) disable iff (!presetn) $rose(motor_stop));
   c_alarm: cover property (@(posedge pclk) disable iff (!presetn) $rose(command_error_alarm));
   c_host_mode: cover property (@(posedge pclk) disable iff (!presetn)
      limit_source_select && !upper_limit_flag);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : slsl_stroke_limit

// [slsl_host_model.sv]
`timescale 1ns/1ps
module slsl_host_model
(
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // set when a transfer got no answer
   output logic hung
);
   // -----------------------------------------
   // controller register access
   // -----------------------------------------
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hFF;
      pwdata = 32'hFFFFFFFF;
      hung = 1'b0;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      q = 32'h0;
      e = 1'b1;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      hung <= (n >= 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so a stale value is never mistaken for a live one
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : slsl_host_model

// [tb_slsl_stroke_limit.sv]
`timescale 1ns/1ps
module tb_slsl_stroke_limit
   import slsl_pkg::*;
   ;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic forward_end_switch, reverse_end_switch, proximity_dog;
   logic upper_limit_flag, lower_limit_flag, dog_flag, motor_stop;
   logic command_error_alarm, home_established, irq;
   logic [1:0] stop_method;
   int err_total = 0;
   int total_checks = 0;
   slsl_stroke_limit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .forward_end_switch(forward_end_switch),
      .reverse_end_switch(reverse_end_switch), .proximity_dog(proximity_dog),
      .upper_limit_flag(upper_limit_flag), .lower_limit_flag(lower_limit_flag),
      .dog_flag(dog_flag), .motor_stop(motor_stop), .stop_method(stop_method),
      .command_error_alarm(command_error_alarm), .home_established(home_established),
      .irq(irq));
   slsl_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hung(hung));
   // -----------------------------------------
   // checking and access helpers
   // -----------------------------------------
   task stop_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   task chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee,
      input logic [31:0] eq);
      logic [31:0] q;
      logic e;
      host.xfer(w, a, d, q, e);
      #1;
      if (hung === 1'b1)
      begin
         err_total++;
         stop_test();
      end
      chk_bit(e, ee);
      if (!w)
         chk_word(q, eq);
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0, 32'h0);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] eq);
      bus(1'b0, a, 32'h0, 1'b0, eq);
   endtask : rd
   // pins reach the flags three edges after they change
   task pins(input logic f, input logic r, input logic d);
      @(posedge pclk);
      forward_end_switch <= f;
      reverse_end_switch <= r;
      proximity_dog <= d;
      repeat (4) @(posedge pclk);
      #1;
   endtask : pins
   task settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task t_reset;
      chk_word({upper_limit_flag, lower_limit_flag, motor_stop, irq}, 32'h0000000C);
      rd(SLSL_OFS_CTRL, 32'h0);
      rd(SLSL_OFS_HOST, 32'h3);
      rd(SLSL_OFS_STATUS, 32'h7);
      bus(1'b0, 8'h20, 32'h0, 1'b1, 32'h0);
      bus(1'b1, 8'h02, 32'h0, 1'b1, 32'h0);
   endtask : t_reset
   task t_map;
      logic f;
      for (int d = 0; d < 2; d++)
         for (int s = 0; s < 2; s++)
         begin
            f = (s == 1);
            wr(SLSL_OFS_CTRL, 32'h10 * (d + 1) + 2 * d);
            pins(f, !f, 1'b1);
            chk_bit(upper_limit_flag, d ? !f : f);
            chk_bit(lower_limit_flag, d ? f : !f);
            chk_bit(motor_stop, 1'b1);
            chk_word(32'(stop_method), 32'(d + 1));
            pins(1'b1, 1'b1, !f);
            chk_bit(motor_stop, 1'b0);
            chk_bit(dog_flag, !f);
         end
      wr(SLSL_OFS_CTRL, 32'h4);
      pins(1'b0, 1'b0, 1'b1);
      chk_bit(motor_stop, 1'b0);
      chk_bit(upper_limit_flag & lower_limit_flag, 1'b1);
   endtask : t_map
   task t_host;
      wr(SLSL_OFS_CTRL, 32'h1);
      wr(SLSL_OFS_HOST, 32'h5);
      pins(1'b0, 1'b0, 1'b0);
      chk_word({upper_limit_flag, lower_limit_flag, dog_flag, motor_stop}, 32'hB);
      wr(SLSL_OFS_CTRL, 32'h5);
      wr(SLSL_OFS_HOST, 32'h2);
      settle();
      chk_word({upper_limit_flag, lower_limit_flag, dog_flag, motor_stop}, 32'h5);
      wr(SLSL_OFS_HOST, 32'h7);
      pins(1'b1, 1'b1, 1'b1);
      wr(SLSL_OFS_CTRL, 32'h0);
   endtask : t_host
   task t_irq;
      wr(SLSL_OFS_INT_STATUS, 32'h3);
      pins(1'b0, 1'b1, 1'b1);
      chk_bit(irq, 1'b0);
      rd(SLSL_OFS_INT_STATUS, 32'h1);
      wr(SLSL_OFS_INT_MASK, 32'h1);
      settle();
      chk_bit(irq, 1'b1);
      wr(SLSL_OFS_INT_STATUS, 32'h1);
      settle();
      chk_bit(irq, 1'b0);
      pins(1'b1, 1'b1, 1'b1);
   endtask : t_irq
   task t_csp;
      wr(SLSL_OFS_ACTION, 32'h1);
      settle();
      chk_bit(home_established, 1'b1);
      wr(SLSL_OFS_CTRL, 32'h8);
      wr(SLSL_OFS_CMD_POS, 32'd100);
      pins(1'b0, 1'b1, 1'b1);
      rd(SLSL_OFS_LATCH_POS, 32'd100);
      wr(SLSL_OFS_CMD_POS, 32'd130);
      settle();
      chk_bit(command_error_alarm, 1'b0);
      wr(SLSL_OFS_CMD_POS, 32'd131);
      settle();
      chk_bit(command_error_alarm, 1'b1);
      chk_bit(home_established, 1'b0);
      rd(SLSL_OFS_INT_STATUS, 32'h3);
      wr(SLSL_OFS_CMD_POS, 32'd100);
      wr(SLSL_OFS_ACTION, 32'h3);
      settle();
      chk_bit(command_error_alarm, 1'b0);
      chk_bit(home_established, 1'b0);
      rd(SLSL_OFS_STATUS, 32'hE);
      wr(SLSL_OFS_ACTION, 32'h1);
      chk_bit(home_established, 1'b1);
      pins(1'b1, 1'b1, 1'b1);
      chk_bit(motor_stop, 1'b0);
      pins(1'b1, 1'b0, 1'b1);
      rd(SLSL_OFS_LATCH_POS, 32'd100);
      wr(SLSL_OFS_CMD_POS, 32'd70);
      settle();
      chk_bit(command_error_alarm, 1'b0);
      wr(SLSL_OFS_CMD_POS, 32'd69);
      settle();
      chk_bit(command_error_alarm, 1'b1);
      chk_bit(home_established, 1'b0);
   endtask : t_csp
   // -----------------------------------------
   // clock, reset and sequence
   // -----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_total++;
      stop_test();
   end
   initial
   begin
      presetn = 1'b0;
      forward_end_switch = 1'b1;
      reverse_end_switch = 1'b1;
      proximity_dog = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      pins(1'b1, 1'b1, 1'b1);
      t_reset();
      t_map();
      t_host();
      t_irq();
      t_csp();
      stop_test();
   end
endmodule : tb_slsl_stroke_limit
